//--- hdl/host_ctl_defs.vh
// constants for the host control interface: register map, field positions, timing counts
// assumes a 200 MHz system clock and an eleven-bit host address
`ifndef HOST_CTL_DEFS_VH
`define HOST_CTL_DEFS_VH

`define CLOCK_PERIOD_NS      5
`define RESET_PIN_MIN_NS     100
`define RESET_PIN_MIN_CYC    ((`RESET_PIN_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define READY_DELAY_MS       2
`define READY_DELAY_CYC      ((`READY_DELAY_MS * 1000000) / `CLOCK_PERIOD_NS)

`define GPIO_CTRL_ADDR       11'h006
`define GPIO_CTRL_RST        8'h00
`define GPIO_DIR_LSB         0
`define GPIO_LEVEL_LSB       2

`define SPI_RW_BIT           14
`define SPI_ADDR_LAST        5'd15
`define SPI_DATA_FIRST       5'd16
`define SPI_DATA_LAST        5'd23
`define SPI_FRAME_END        5'd24

`endif

//--- hdl/spi_port.v
// serial host port: 16-bit header (read bit first, 4 reserved, 11 address bits) then 8 data bits, msb first
// assumes serial clock and select are synchronous inputs, each serial clock phase lasting at least 4 clocks
`timescale 1ns/1ps
`include "host_ctl_defs.vh"

module spi_port
(
  input  wire        clock,
  input  wire        rst,
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        serial_in_line,
  input  wire [7:0]  rdata,
  output wire [10:0] addr,
  output wire [7:0]  wdata,
  output wire        wr,
  output wire        rd,
  output wire        serial_out_line,
  output wire        sdo_oe
);

  reg        sclk_ff;
  reg [4:0]  cnt_ff;
  reg [14:0] hdr_ff;
  reg        is_rd_ff;
  reg [10:0] addr_ff;
  reg [7:0]  wdata_ff;
  reg        wr_ff;
  reg        rd_ff;
  reg        sdo_ff;
  reg        sdo_oe_ff;

  wire rise = sclk & ~sclk_ff;
  wire fall = ~sclk & sclk_ff;
  wire in_data = (cnt_ff >= `SPI_DATA_FIRST) && (cnt_ff <= `SPI_DATA_LAST);

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclk_ff   <= 1'b0;
      cnt_ff    <= 5'd0;
      hdr_ff    <= 15'h0000;
      is_rd_ff  <= 1'b0;
      addr_ff   <= 11'h000;
      wdata_ff  <= 8'h00;
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      sdo_ff    <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end
    else
    begin
      sclk_ff <= sclk;
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
      if (cs_n)
      begin
        cnt_ff    <= 5'd0;
        is_rd_ff  <= 1'b0;
        sdo_oe_ff <= 1'b0;
      end
      else
      begin
        if (rise && (cnt_ff < `SPI_FRAME_END))
        begin
          cnt_ff <= cnt_ff + 5'd1;
          if (cnt_ff < `SPI_DATA_FIRST)
            hdr_ff <= {hdr_ff[13:0], serial_in_line};
          if (cnt_ff == `SPI_ADDR_LAST)
          begin
            addr_ff  <= {hdr_ff[9:0], serial_in_line};
            is_rd_ff <= hdr_ff[`SPI_RW_BIT];
            rd_ff    <= hdr_ff[`SPI_RW_BIT];
          end
          if (in_data)
            wdata_ff <= {wdata_ff[6:0], serial_in_line};
          if ((cnt_ff == `SPI_DATA_LAST) && !is_rd_ff)
            wr_ff <= 1'b1;
        end
        if (fall && is_rd_ff && in_data)
        begin
          sdo_oe_ff <= 1'b1;
          sdo_ff    <= rdata[~cnt_ff[2:0]];
        end
      end
    end
  end

  assign addr   = addr_ff;
  assign wdata  = wdata_ff;
  assign wr     = wr_ff;
  assign rd     = rd_ff;
  assign serial_out_line    = sdo_ff;
  assign sdo_oe = sdo_oe_ff;

endmodule

//--- hdl/host_control_interface.v
// host control interface: byte-wide parallel or serial host port, device reset, two general pins,
// interrupt pin and line transmit tristate
// assumes all pins are already synchronous to clock; other registers answer on the reg_* port
`timescale 1ns/1ps
`include "host_ctl_defs.vh"

module host_control_interface
#(
  parameter        NUM_LINKS    = 8,
  parameter        NUM_IRQ      = 8,
  parameter [31:0] READY_CYCLES = `READY_DELAY_CYC
)
(
  input  wire                 clock,
  input  wire                 rst,
  input  wire                 chip_reset_n,
  input  wire                 cs_n,
  input  wire [10:0]          addr,
  input  wire [7:0]           data_in,
  output wire [7:0]           data_out,
  output wire [7:0]           data_oe,
  input  wire                 rw_wr_sdi,
  input  wire                 ds_rd_sclk,
  input  wire                 bus_style_select,
  input  wire                 serial_host_select,
  input  wire [1:0]           gpio_in,
  output wire [1:0]           gpio_out,
  output wire [1:0]           gpio_oe,
  input  wire                 line_tristate_input,
  output wire [NUM_LINKS-1:0] line_transmit_pair_oe,
  input  wire [NUM_IRQ-1:0]   irq_active,
  input  wire [NUM_IRQ-1:0]   irq_unmask,
  output wire                 int_n_out,
  output wire                 int_n_oe,
  output wire                 core_reset,
  output wire                 regs_ready,
  output wire [10:0]          reg_addr,
  output wire [7:0]           reg_wdata,
  output wire                 reg_wr,
  output wire                 reg_rd,
  input  wire [7:0]           reg_rdata
);

  localparam [7:0] RST_MIN  = `RESET_PIN_MIN_CYC;
  localparam [7:0] GPIO_RST = `GPIO_CTRL_RST;

  reg [7:0]           rpin_cnt_ff;
  reg                 core_reset_ff;
  reg [31:0]          ready_cnt_ff;
  reg                 ready_ff;
  reg                 test_mode_ff;
  reg                 done_ff;
  reg                 prd_grant_ff;
  reg                 pwr_grant_ff;
  reg [10:0]          lat_addr_ff;
  reg [7:0]           lat_data_ff;
  reg [1:0]           dir_ff;
  reg [1:0]           level_ff;
  reg [1:0]           gpio_in_ff;
  reg [10:0]          reg_addr_ff;
  reg [7:0]           reg_wdata_ff;
  reg                 reg_wr_ff;
  reg                 reg_rd_ff;
  reg                 spi_cap_ff;
  reg [7:0]           spi_rdata_ff;
  reg [7:0]           par_dout_ff;
  reg                 int_oe_ff;
  reg [NUM_LINKS-1:0] line_oe_ff;

  wire [10:0] spi_addr;
  wire [7:0]  spi_wdata;
  wire        spi_wr;
  wire        spi_rd;
  wire        spi_sdo;
  wire        spi_sdo_oe;

  wire access_ok = ready_ff & ~test_mode_ff & ~core_reset_ff;
  wire par_sel   = ~cs_n & ~serial_host_select & access_ok;
  wire spi_cs_n  = cs_n | ~serial_host_select | ~access_ok;

  // strobe decode; the style pin is only looked at in parallel mode
  wire prd_act = par_sel & (bus_style_select ? ~ds_rd_sclk : (~ds_rd_sclk & rw_wr_sdi));
  wire pwr_act = par_sel & (bus_style_select ? ~rw_wr_sdi : (~ds_rd_sclk & ~rw_wr_sdi));
  wire idle    = ~done_ff & ~prd_grant_ff & ~pwr_grant_ff;
  wire prd_go  = prd_act & idle;
  wire pwr_go  = pwr_act & idle;
  wire pwr_end = pwr_grant_ff & ~pwr_act;

  wire        wr_go   = serial_host_select ? spi_wr : pwr_end;
  wire [10:0] wr_addr = serial_host_select ? spi_addr : lat_addr_ff;
  wire [7:0]  wr_data = serial_host_select ? spi_wdata : lat_data_ff;
  wire        wr_loc  = (wr_addr == `GPIO_CTRL_ADDR);

  // level bits read the pin when it is an input, the written value when it is an output
  wire [1:0] level_rb = (dir_ff & level_ff) | (~dir_ff & gpio_in_ff);
  wire [7:0] gpio_rb  = {4'h0, level_rb, dir_ff};
  wire [7:0] rd_value = (reg_addr_ff == `GPIO_CTRL_ADDR) ? gpio_rb : reg_rdata;

  spi_port u_spi
  (
    .clock  (clock),
    .rst    (rst),
    .cs_n   (spi_cs_n),
    .sclk   (ds_rd_sclk),
    .serial_in_line    (rw_wr_sdi),
    .rdata  (spi_rdata_ff),
    .addr   (spi_addr),
    .wdata  (spi_wdata),
    .wr     (spi_wr),
    .rd     (spi_rd),
    .serial_out_line    (spi_sdo),
    .sdo_oe (spi_sdo_oe)
  );

  // chip reset pin filter and the post-reset access delay
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rpin_cnt_ff   <= 8'h00;
      core_reset_ff <= 1'b0;
      ready_cnt_ff  <= 32'h00000000;
      ready_ff      <= 1'b0;
      test_mode_ff  <= 1'b1;
    end
    else
    begin
      if (chip_reset_n)
      begin
        rpin_cnt_ff   <= 8'h00;
        core_reset_ff <= 1'b0;
      end
      else if (rpin_cnt_ff == RST_MIN)
        core_reset_ff <= 1'b1;
      else
        rpin_cnt_ff <= rpin_cnt_ff + 8'h01;
      if (core_reset_ff)
      begin
        ready_cnt_ff <= 32'h00000000;
        ready_ff     <= 1'b0;
      end
      else if (ready_cnt_ff != READY_CYCLES)
        ready_cnt_ff <= ready_cnt_ff + 32'h00000001;
      else
        ready_ff <= 1'b1;
      if (cs_n)
        test_mode_ff <= 1'b0;
    end
  end

  // host access sequencing and register file
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      done_ff      <= 1'b0;
      prd_grant_ff <= 1'b0;
      pwr_grant_ff <= 1'b0;
      lat_addr_ff  <= 11'h000;
      lat_data_ff  <= 8'h00;
      dir_ff       <= 2'b00;
      level_ff     <= 2'b00;
      gpio_in_ff   <= 2'b00;
      reg_addr_ff  <= 11'h000;
      reg_wdata_ff <= 8'h00;
      reg_wr_ff    <= 1'b0;
      reg_rd_ff    <= 1'b0;
      spi_cap_ff   <= 1'b0;
      spi_rdata_ff <= 8'h00;
      par_dout_ff  <= 8'h00;
    end
    else if (core_reset_ff)
    begin
      done_ff      <= 1'b0;
      prd_grant_ff <= 1'b0;
      pwr_grant_ff <= 1'b0;
      dir_ff       <= GPIO_RST[`GPIO_DIR_LSB+1:`GPIO_DIR_LSB];
      level_ff     <= GPIO_RST[`GPIO_LEVEL_LSB+1:`GPIO_LEVEL_LSB];
      reg_wr_ff    <= 1'b0;
      reg_rd_ff    <= 1'b0;
      spi_cap_ff   <= 1'b0;
    end
    else
    begin
      gpio_in_ff <= gpio_in;
      if (cs_n)
        done_ff <= 1'b0;
      else if (prd_go || pwr_go)
        done_ff <= 1'b1;
      if (prd_go)
        prd_grant_ff <= 1'b1;
      else if (!prd_act)
        prd_grant_ff <= 1'b0;
      if (pwr_go)
        pwr_grant_ff <= 1'b1;
      else if (!pwr_act)
        pwr_grant_ff <= 1'b0;
      if (pwr_act)
      begin
        lat_addr_ff <= addr;
        lat_data_ff <= data_in;
      end
      if (wr_go && wr_loc)
      begin
        dir_ff   <= wr_data[`GPIO_DIR_LSB+1:`GPIO_DIR_LSB];
        level_ff <= wr_data[`GPIO_LEVEL_LSB+1:`GPIO_LEVEL_LSB];
      end
      reg_addr_ff  <= serial_host_select ? spi_addr : (wr_go ? lat_addr_ff : addr);
      reg_wdata_ff <= wr_data;
      reg_wr_ff    <= wr_go & ~wr_loc;
      reg_rd_ff    <= serial_host_select ? (spi_rd & (spi_addr != `GPIO_CTRL_ADDR))
                                         : (prd_go & (addr != `GPIO_CTRL_ADDR));
      spi_cap_ff   <= spi_rd;
      if (spi_cap_ff)
        spi_rdata_ff <= rd_value;
      if (prd_grant_ff)
        par_dout_ff <= rd_value;
    end
  end

  // pin-facing outputs
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      int_oe_ff  <= 1'b0;
      line_oe_ff <= {NUM_LINKS{1'b0}};
    end
    else
    begin
      int_oe_ff  <= |(irq_active & irq_unmask);
      line_oe_ff <= {NUM_LINKS{~line_tristate_input}};
    end
  end

  assign data_out = serial_host_select ? {7'h00, spi_sdo} : par_dout_ff;
  assign data_oe  = serial_host_select ? {7'h00, spi_sdo_oe} : {8{prd_grant_ff & prd_act}};
  assign gpio_out              = level_ff;
  assign gpio_oe               = dir_ff;
  assign int_n_out             = 1'b0;
  assign int_n_oe              = int_oe_ff;
  assign line_transmit_pair_oe = line_oe_ff;
  assign core_reset            = core_reset_ff;
  assign regs_ready            = access_ok;
  assign reg_addr              = reg_addr_ff;
  assign reg_wdata             = reg_wdata_ff;
  assign reg_wr                = reg_wr_ff;
  assign reg_rd                = reg_rd_ff;

endmodule

//--- tb/host_ctl_props.sv
// assertions on the host control interface pins
// bound into host_control_interface, sees its ports only
`timescale 1ns/1ps
module host_ctl_props
#(
  parameter NUM_LINKS = 8,
  parameter NUM_IRQ   = 8
)
(
  input wire                 clock,
  input wire                 rst,
  input wire                 chip_reset_n,
  input wire                 cs_n,
  input wire                 serial_host_select,
  input wire [7:0]           data_out,
  input wire [7:0]           data_oe,
  input wire                 line_tristate_input,
  input wire [NUM_LINKS-1:0] line_transmit_pair_oe,
  input wire [NUM_IRQ-1:0]   irq_active,
  input wire [NUM_IRQ-1:0]   irq_unmask,
  input wire                 int_n_out,
  input wire                 int_n_oe,
  input wire                 core_reset,
  input wire                 regs_ready,
  input wire                 reg_wr,
  input wire                 reg_rd
);
  // consecutive low samples of the reset pin, saturating
  reg [4:0] low_ff;
  always @(posedge clock or posedge rst)
    if (rst)
      low_ff <= 5'h00;
    else if (chip_reset_n)
      low_ff <= 5'h00;
    else if (low_ff != 5'h1f)
      low_ff <= low_ff + 5'h01;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_tx_pair_off: assert property (line_tristate_input |=> line_transmit_pair_oe == 0)
    else $error("transmit pair left on");
  a_irq_pin_follow: assert property (##1 int_n_oe == $past(|(irq_active & irq_unmask)) && !int_n_out)
    else $error("interrupt pin wrong");
  a_short_low_ignored: assert property (low_ff < 5'd21 && !$past(core_reset) |-> !core_reset)
    else $error("short reset pulse acted");
  a_long_low_resets: assert property (low_ff >= 5'd21 |-> core_reset)
    else $error("long reset pulse missed");
  a_reset_release: assert property (chip_reset_n [*3] |-> !core_reset)
    else $error("core reset stuck");
  a_ready_gates_read: assert property (!$past(regs_ready) |-> !reg_rd)
    else $error("read before ready");
  a_cs_high_quiet: assert property (cs_n && $past(cs_n) |-> !reg_rd)
    else $error("read without select");
  a_par_bus_free: assert property (!serial_host_select && cs_n |-> data_oe == 8'h00)
    else $error("bus driven while deselected");
  a_serial_one_pin: assert property (serial_host_select [*3] |-> data_oe[7:1] == 7'h00 && data_out[7:1] == 7'h00)
    else $error("serial mode upper bits");
  a_read_one_pulse: assert property (reg_rd |=> !reg_rd)
    else $error("read pulse too long");
  c_read: cover property (reg_rd);
  c_write: cover property (reg_wr);
  c_core_reset: cover property (core_reset);
endmodule

bind host_control_interface host_ctl_props #(.NUM_LINKS(NUM_LINKS), .NUM_IRQ(NUM_IRQ)) props_u
  (.clock, .rst, .chip_reset_n, .cs_n, .serial_host_select, .data_out, .data_oe, .line_tristate_input,
   .line_transmit_pair_oe, .irq_active, .irq_unmask, .int_n_out, .int_n_oe, .core_reset, .regs_ready,
   .reg_wr, .reg_rd);

//--- tb/host_cpu_model.sv
// host processor model for the parallel and serial host port
// caller chooses serial_host_select; each serial clock phase lasts 4 clocks
`timescale 1ns/1ps
module host_cpu_model
(
  input  wire        clock,
  input  wire [7:0]  data_out,
  input  wire [7:0]  data_oe,
  output reg         cs_n = 1'b1,
  output reg  [10:0] addr = 11'h000,
  output wire [7:0]  data_in,
  output reg         rw_wr_sdi = 1'b1,
  output reg         ds_rd_sclk = 1'b1,
  output reg         bus_style_select = 1'b0
);
  reg [7:0] hd = 8'h00;
  reg       drv = 1'b0;
  // released bus shows the inverse of hd, the byte last passed to par, including the 00 of a read
  assign data_in = (data_oe & data_out) | (~data_oe & (drv ? hd : ~hd));
  task par(input st, input rd, input [10:0] a, input [7:0] w, output [7:0] r);
    @(posedge clock) #1;
    bus_style_select = st;
    cs_n = 1'b0;
    addr = a;
    hd = w;
    drv = !rd;
    if (!st)
      {rw_wr_sdi, ds_rd_sclk} = {rd, 1'b0};
    else if (rd)
      ds_rd_sclk = 1'b0;
    else
      rw_wr_sdi = 1'b0;
    repeat (4) @(posedge clock);
    #1 r = data_out;
    {rw_wr_sdi, ds_rd_sclk} = 2'b11;
    @(posedge clock) #1 cs_n = 1'b1;
    drv = 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task spi(input [23:0] f, output [7:0] r);
    integer i;
    @(posedge clock) #1 ds_rd_sclk = 1'b0;
    bus_style_select = 1'b1;
    @(posedge clock) #1 cs_n = 1'b0;
    for (i = 23; i >= 0; i = i - 1)
    begin
      rw_wr_sdi = f[i];
      repeat (4) @(posedge clock);
      #1 ds_rd_sclk = 1'b1;
      if (i < 8)
        r[i] = data_out[0];
      repeat (4) @(posedge clock);
      #1 ds_rd_sclk = 1'b0;
    end
    @(posedge clock) #1 cs_n = 1'b1;
    rw_wr_sdi = ~rw_wr_sdi;
  endtask
endmodule

//--- tb/host_control_interface_test.sv
// self-checking bench for host_control_interface driven by the host model
// ready delay shortened to 50 cycles; other registers answer their address xor 5a
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module host_control_interface_test;
  reg          clock = 1'b0;
  reg          rst = 1'b1;
  reg          chip_reset_n = 1'b1;
  reg          serial_host_select = 1'b0;
  reg          line_tristate_input = 1'b0;
  reg  [1:0]   gpio_ext = 2'b11;
  reg  [7:0]   irq_active = 8'h00;
  reg  [7:0]   irq_unmask = 8'h00;
  wire         cs_n, rw_wr_sdi, ds_rd_sclk, bus_style_select, int_n_out, int_n_oe;
  wire         core_reset, regs_ready, reg_wr, reg_rd;
  wire [10:0]  addr, reg_addr;
  wire [7:0]   data_in, data_out, data_oe, line_transmit_pair_oe, reg_wdata, reg_rdata;
  wire [1:0]   gpio_in, gpio_out, gpio_oe;
  reg  [7:0]   r, w, ex, wd;
  reg  [10:0]  wa;
  reg          st;
  reg  [1:0]   ext;
  integer      k, errors = 0, n_checks = 0, rd_cnt = 0, wr_cnt = 0;
  reg  [18:0]  rows [0:3] = '{{1'b0, 8'h0c, 2'b01, 8'h04}, {1'b1, 8'hf7, 2'b10, 8'h07},
                              {1'b0, 8'h09, 2'b10, 8'h09}, {1'b1, 8'h0a, 2'b11, 8'h0e}};
  assign reg_rdata = reg_addr[7:0] ^ 8'h5a;
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_ext);
  host_cpu_model host_u (.clock, .data_out, .data_oe, .cs_n, .addr, .data_in, .rw_wr_sdi, .ds_rd_sclk,
                         .bus_style_select);
  host_control_interface #(.READY_CYCLES(50)) dut_u (.clock, .rst, .chip_reset_n, .cs_n, .addr, .data_in,
    .data_out, .data_oe, .rw_wr_sdi, .ds_rd_sclk, .bus_style_select, .serial_host_select, .gpio_in, .gpio_out,
    .gpio_oe, .line_tristate_input, .line_transmit_pair_oe, .irq_active, .irq_unmask, .int_n_out, .int_n_oe,
    .core_reset, .regs_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  always @(posedge clock)
  begin
    rd_cnt <= rd_cnt + reg_rd;
    if (reg_wr)
      {wr_cnt, wa, wd} <= {wr_cnt + 1, reg_addr, reg_wdata};
  end
  task summarize;
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task irq(input [7:0] a, input [7:0] m, input e);
    {irq_active, irq_unmask} = {a, m};
    repeat (2) @(posedge clock);
    #1 `CHK(int_n_oe, e)
  endtask
  initial
    forever #2.5 clock = ~clock;
  initial
  begin
    #20000 errors++;
    summarize;
  end
  initial
  begin
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    host_u.par(1'b1, 1'b1, 11'h155, 8'h00, r);
    `CHK(rd_cnt, 0)
    repeat (26) @(posedge clock);
    `CHK(regs_ready, 1'b0)
    repeat (20) @(posedge clock);
    `CHK(regs_ready, 1'b1)
    for (k = 0; k < 4; k++)
    begin
      {st, w, ext, ex} = rows[k];
      gpio_ext = ext;
      host_u.par(st, 1'b0, 11'h006, w, r);
      `CHK(gpio_oe, w[1:0])
      `CHK(gpio_out & gpio_oe, w[3:2] & w[1:0])
      host_u.par(st, 1'b1, 11'h006, 8'h00, r);
      `CHK(r, ex)
    end
    host_u.par(1'b0, 1'b0, 11'h3a5, 8'h96, r);
    `CHK({wr_cnt, wa, wd}, {32'd1, 11'h3a5, 8'h96})
    host_u.par(1'b1, 1'b1, 11'h155, 8'h00, r);
    `CHK({rd_cnt, r}, {32'd1, 8'h0f})
    serial_host_select = 1'b1;
    host_u.spi({1'b1, 4'h0, 11'h006, 8'h00}, r);
    `CHK(r, 8'h0e)
    host_u.spi({1'b0, 4'h0, 11'h006, 8'h05}, r);
    `CHK({gpio_oe, gpio_out & gpio_oe}, {2'b01, 2'b01})
    repeat (4) @(posedge clock);
    #1 serial_host_select = 1'b0;
    line_tristate_input = 1'b1;
    repeat (2) @(posedge clock);
    #1 `CHK(line_transmit_pair_oe, 8'h00)
    line_tristate_input = 1'b0;
    repeat (2) @(posedge clock);
    #1 `CHK(line_transmit_pair_oe, 8'hff)
    irq(8'h24, 8'h04, 1'b1);
    irq(8'h24, 8'h00, 1'b0);
    irq(8'h00, 8'hff, 1'b0);
    chip_reset_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 `CHK(core_reset, 1'b0)
    chip_reset_n = 1'b1;
    repeat (3) @(posedge clock);
    #1 chip_reset_n = 1'b0;
    repeat (22) @(posedge clock);
    #1 `CHK(core_reset, 1'b1)
    chip_reset_n = 1'b1;
    repeat (60) @(posedge clock);
    host_u.par(1'b0, 1'b1, 11'h006, 8'h00, r);
    `CHK({gpio_oe, r}, {2'b00, 8'h0c})
    summarize;
  end
endmodule
